/* File: dv/program_result_status_sva.sv */
/* checker for the programming result byte.
 assumes binding to program_result_status, flash window taken from its parameters. */
`timescale 1ns/100ps
module program_result_status_sva
#(parameter [31:0] FLASH_BASE = 32'h0, parameter [31:0] FLASH_LIMIT = 32'h1ffff)
(input wire clk, rst, start, done, write_failed, write_enable_pin, protection_error_flag,
 input wire [7:0] flash_unlock_key_reg, memory_area_select_reg,
 input wire [31:0] source_addr, dest_addr,
 input wire write_allowed, input wire [7:0] flash_control_status_reg, program_result_code,
 input wire result_valid, busy);
reg [3:0] chk_q;
wire [7:0] c = program_result_code;
always @(posedge clk or posedge rst)
    if (rst) chk_q <= 4'h0;
    else if (start && !busy) chk_q <= {memory_area_select_reg == 8'haa,
        dest_addr < FLASH_BASE || dest_addr > FLASH_LIMIT || dest_addr[6:0] != 7'h00,
        source_addr >= FLASH_BASE && source_addr <= FLASH_LIMIT, flash_unlock_key_reg != 8'h5a};
default clocking @(posedge clk); endclocking
default disable iff (rst);
sequence done_taken; done && busy; endsequence
a_unused_zero: assert property (result_valid |-> !c[7] && !c[3]) else $error("unused bit");
a_key_flag: assert property (result_valid |-> c[4] == chk_q[0]) else $error("key bit");
a_src_flag: assert property (result_valid |-> c[2] == chk_q[1]) else $error("src bit");
a_dst_flag: assert property (result_valid |-> c[1] == chk_q[2]) else $error("dst bit");
a_boot_fails: assert property (result_valid && chk_q[3] |-> c[5]) else $error("boot");
a_boot_nowrite: assert property (busy && chk_q[3] |-> !write_allowed) else $error("wr");
a_fail_sum: assert property (result_valid |-> c[0] == |c[6:1]) else $error("fail bit");
a_status_split: assert property (!$past(rst) |-> flash_control_status_reg ==
    {$past(protection_error_flag), 6'h0, $past(write_enable_pin)}) else $error("stat");
a_valid_pulse: assert property (done_taken |=> result_valid ##1 !result_valid)
    else $error("valid pulse");
a_valid_cause: assert property (result_valid |-> $past(done && busy)) else $error("vc");
endmodule // program_result_status_sva
bind program_result_status program_result_status_sva
    #(.FLASH_BASE(FLASH_BASE), .FLASH_LIMIT(FLASH_LIMIT)) program_result_status_sva_i (.*);

/* File: dv/test_program_result_status.sv */
/* random bench for the programming result byte.
 assumes default flash window 0..1ffff. */
`timescale 1ns/100ps
module test_program_result_status;
reg clk = 0, rst = 1, start = 0, done = 0, wf = 0, pin = 1, prot = 0;
reg [7:0] key = 0, mas = 0;
reg [31:0] src = 0, dst = 0;
wire wa, rv, busy;
wire [7:0] fcs, code;
integer seed = 75063, error_cnt = 0, tests_run = 0, cyc = 0, i;
program_result_status program_result_status_i (.clk(clk), .rst(rst), .start(start),
    .done(done), .write_failed(wf), .write_enable_pin(pin), .protection_error_flag(prot),
    .flash_unlock_key_reg(key), .memory_area_select_reg(mas), .source_addr(src),
    .dest_addr(dst), .write_allowed(wa), .flash_control_status_reg(fcs),
    .program_result_code(code), .result_valid(rv), .busy(busy));
initial forever #2 clk = ~clk;
function [7:0] exp_code(input x);
    reg m, k, s, d, b, e;
    begin
    m = !pin || prot; k = key != 8'h5a; s = src <= 32'h1ffff; b = mas == 8'haa;
    d = dst > 32'h1ffff || dst[6:0] != 7'h00; e = b || (wf && !(m | k | s | d));
    exp_code = {1'b0, m, e, k, 1'b0, s, d, m | e | k | s | d};
    end
endfunction
function exp_wa(input x);
    begin
    exp_wa = !(!pin || prot || key != 8'h5a || src <= 32'h1ffff || mas == 8'haa
        || dst > 32'h1ffff || dst[6:0] != 7'h00);
    end
endfunction
task chk(input [63:0] nm, input [7:0] exp, got);
    begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, got);
    end
    end
endtask
task stop_test;
    begin
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
    end
endtask
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (cyc > 2000)
    begin
        error_cnt = error_cnt + 1;
        stop_test;
    end
end
initial
begin
    repeat (6) @(negedge clk);
    rst = 0;
    for (i = 0; i < 80; i = i + 1)
    begin
        key = ($random(seed) & 1) ? 8'h5a : $random(seed);
        mas = (i == 1 || ($random(seed) & 3) == 0) ? 8'haa : $random(seed);
        src = $random(seed) & 32'h3ffff;
        dst = $random(seed) & (($random(seed) & 1) ? 32'h3ff80 : 32'h3ffff);
        pin = ($random(seed) & 7) != 0;
        prot = ($random(seed) & 7) == 0;
        wf = $random(seed);
        if (i == 0) {key, mas, src, dst, pin, prot, wf} = {8'h5a, 8'h0, 32'h20000, 32'h1ff80, 3'h4};
        @(negedge clk) start = 1; // caller keeps each call fresh
        @(negedge clk) start = 0;
        chk("busy", 8'h1, {7'h0, busy});
        chk("wr_ok", {7'h0, exp_wa(0)}, {7'h0, wa});
        done = 1;
        @(negedge clk) done = 0;
        chk("valid", 8'h1, {7'h0, rv});
        chk("code", exp_code(0), code);
        chk("status", {prot, 6'h0, pin}, fcs);
        chk("idle", 8'h0, {7'h0, busy});
        done = 1;
        @(negedge clk) done = 0;
        chk("stray", 8'h0, {7'h0, rv});
        $display("call %0d ended", i);
    end
    stop_test;
end
endmodule // test_program_result_status

/* File: inc/prog_result_defs.vh */
/*
 constants for the flash programming result block.
 assumes inclusion by bare name from logic files.
*/
`ifndef PROG_RESULT_DEFS_VH
`define PROG_RESULT_DEFS_VH
`define BIT_SUCCESS_FAIL      0
`define BIT_DEST_ADDR_ERR     1
`define BIT_SRC_ADDR_ERR      2
`define BIT_KEY_CHECK_ERR     4
`define BIT_EXEC_ERR          5
`define BIT_MODE_ERR          6
`define UNLOCK_KEY_VALUE      8'h5a
`define BOOT_AREA_SELECT      8'haa
`define BOUNDARY_LOW_0        8'h00
`define BOUNDARY_LOW_1        8'h80
`define FLASH_BASE_DEFAULT    32'h0000_0000
`define FLASH_LIMIT_DEFAULT   32'h0001_ffff
`define RESULT_RESET          8'h00
`endif

/* File: logic/addr_range_check.v */
/*
 address checker: inside a flash window, and 128-byte boundary.
 assumes base and limit are inclusive bounds.
*/
`timescale 1ns/100ps
`include "prog_result_defs.vh"
module addr_range_check
#(
    parameter [31:0] BASE  = `FLASH_BASE_DEFAULT,
    parameter [31:0] LIMIT = `FLASH_LIMIT_DEFAULT
)
(
    input  wire [31:0] addr,
    output wire        in_flash,
    output wire        on_boundary
);
    assign in_flash    = (addr >= BASE) && (addr <= LIMIT);
    assign on_boundary = (addr[7:0] == `BOUNDARY_LOW_0) || (addr[7:0] == `BOUNDARY_LOW_1);
endmodule // addr_range_check

/* File: logic/program_result_status.v */
/*
 builds the 8-bit result byte of one flash programming call.
 assumes the caller pulses start with its inputs stable, and later
 pulses done with write_failed once the programming attempt ends.
*/
// Overview of operation
// - bits 7 and 3 always read zero
// - bit 6 set on pin low or protection
// - pin and protection flag readable separately
// - bit 5 set when boot area selected or the write fails
// - boot area selected fails, nothing written
// - bit 4 set unless key equals 5a
// - bit 2 set when source inside flash
// - bit 1 on bad destination or boundary
// - bit 0 set on abnormal end
`timescale 1ns/100ps
`include "prog_result_defs.vh"
module program_result_status
#(
    parameter [31:0] FLASH_BASE  = `FLASH_BASE_DEFAULT,
    parameter [31:0] FLASH_LIMIT = `FLASH_LIMIT_DEFAULT
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire        start,
    input  wire        done,
    input  wire        write_failed,
    input  wire        write_enable_pin,
    input  wire        protection_error_flag,
    input  wire [7:0]  flash_unlock_key_reg,
    input  wire [7:0]  memory_area_select_reg,
    input  wire [31:0] source_addr,
    input  wire [31:0] dest_addr,
    output wire        write_allowed,
    output reg  [7:0]  flash_control_status_reg,
    output reg  [7:0]  program_result_code,
    output reg         result_valid,
    output reg         busy
);
    ////////////////////////////////////////////////////////////////////
    wire src_in_flash;
    wire dst_in_flash;
    wire dst_boundary;
    wire mode_setting_error;
    wire key_check_error;
    wire source_address_error;
    wire destination_address_error;
    wire boot_selected;
    reg  [7:0] checks_q;

    addr_range_check #(.BASE(FLASH_BASE), .LIMIT(FLASH_LIMIT)) u_src
    (
        .addr        (source_addr),
        .in_flash    (src_in_flash),
        .on_boundary ()
    );
    addr_range_check #(.BASE(FLASH_BASE), .LIMIT(FLASH_LIMIT)) u_dst
    (
        .addr        (dest_addr),
        .in_flash    (dst_in_flash),
        .on_boundary (dst_boundary)
    );

    ////////////////////////////////////////////////////////////////////
    assign mode_setting_error = ~write_enable_pin | protection_error_flag;
    assign key_check_error = (flash_unlock_key_reg != `UNLOCK_KEY_VALUE);
    assign source_address_error = src_in_flash;
    assign destination_address_error = ~dst_in_flash | ~dst_boundary;
    assign boot_selected = (memory_area_select_reg == `BOOT_AREA_SELECT);
    // no write while any pre-check fails or boot area selected
    assign write_allowed = busy & ~checks_q[`BIT_MODE_ERR] & ~checks_q[`BIT_KEY_CHECK_ERR]
                         & ~checks_q[`BIT_SRC_ADDR_ERR] & ~checks_q[`BIT_DEST_ADDR_ERR]
                         & ~checks_q[`BIT_EXEC_ERR];

    ////////////////////////////////////////////////////////////////////
    // live status copy of pin and protection flag
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            flash_control_status_reg <= `RESULT_RESET;
        else
            flash_control_status_reg <= {protection_error_flag, 6'h00, write_enable_pin};
    end

    ////////////////////////////////////////////////////////////////////
    // capture checks at start, report once at done
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            checks_q            <= `RESULT_RESET;
            program_result_code <= `RESULT_RESET;
            result_valid        <= 1'b0;
            busy                <= 1'b0;
        end
        else
        begin
            result_valid <= 1'b0;
            if (start && !busy)
            begin
                busy     <= 1'b1;
                checks_q <= `RESULT_RESET;
                checks_q[`BIT_MODE_ERR]      <= mode_setting_error;
                checks_q[`BIT_EXEC_ERR]      <= boot_selected;
                checks_q[`BIT_KEY_CHECK_ERR] <= key_check_error;
                checks_q[`BIT_SRC_ADDR_ERR]  <= source_address_error;
                checks_q[`BIT_DEST_ADDR_ERR] <= destination_address_error;
            end
            else if (done && busy)
            begin
                busy         <= 1'b0;
                result_valid <= 1'b1;
                program_result_code <= {1'b0,
                    checks_q[`BIT_MODE_ERR],
                    checks_q[`BIT_EXEC_ERR] | (write_allowed & write_failed),
                    checks_q[`BIT_KEY_CHECK_ERR],
                    1'b0,
                    checks_q[`BIT_SRC_ADDR_ERR],
                    checks_q[`BIT_DEST_ADDR_ERR],
                    (|checks_q) | (write_allowed & write_failed)};
            end
        end
    end
endmodule // program_result_status
